// File: rtl/pcx_pkg.sv
// Package of constants and carrier types for the port crossbar block.
package pcx_pkg;

	// ==================================================================
	// Sizes.
	localparam int NPIN   = 24;
	localparam int NFUNC  = 22;
	localparam int ADDR_W = 8;

	// ==================================================================
	// Register byte offsets.
	localparam logic [7:0] OFF_FUNC_SEL_A = 8'h00;
	localparam logic [7:0] OFF_FUNC_SEL_B = 8'h04;
	localparam logic [7:0] OFF_SPI_CTRL   = 8'h08;
	localparam logic [7:0] OFF_IN_MODE    = 8'h0c;
	localparam logic [7:0] OFF_OUT_MODE   = 8'h10;
	localparam logic [7:0] OFF_SKIP       = 8'h14;
	localparam logic [7:0] OFF_PORT       = 8'h18;
	localparam logic [7:0] OFF_OVERDRIVE  = 8'h1c;
	localparam logic [7:0] OFF_LATCH      = 8'h20;

	// ==================================================================
	// Reset values.
	localparam logic [23:0] IN_MODE_RST  = 24'hffffff;
	localparam logic [23:0] LATCH_RST    = 24'hffffff;
	localparam logic [23:0] OUT_MODE_RST = 24'h000000;
	localparam logic [23:0] SKIP_RST     = 24'h000000;
	localparam logic [7:0]  FSEL_RST     = 8'h00;
	localparam logic [7:0]  OD_RST       = 8'h00;
	localparam logic [1:0]  SSMODE_RST   = 2'h0;

	// ==================================================================
	// Field positions in function_select_a.
	localparam int FA_UART   = 0;
	localparam int FA_SPI    = 1;
	localparam int FA_SMB    = 2;
	localparam int FA_SYSCLK = 3;
	localparam int FA_CP0    = 4;
	localparam int FA_CP0A   = 5;
	localparam int FA_CP1    = 6;
	localparam int FA_CP1A   = 7;
	// Field positions in function_select_b.
	localparam int FB_PCA_LO = 0;
	localparam int FB_ECI    = 3;
	localparam int FB_T0     = 4;
	localparam int FB_T1     = 5;
	localparam int FB_CROSSBAR_ENABLE_BIT  = 6;
	localparam int FB_PULLUP_DISABLE_BIT = 7;
	localparam logic [2:0] PCA_RESERVED = 3'h7;
	localparam logic [1:0] SSMODE_3WIRE = 2'h0;

	// ==================================================================
	// Function slots in priority order; slot number plus one is the code
	// held in the pin map, code zero meaning a general-purpose pin.
	localparam int SL_TX     = 0;
	localparam int SL_RX     = 1;
	localparam int SL_SDA    = 2;
	localparam int SL_SCL    = 3;
	localparam int SL_SCK    = 4;
	localparam int SL_MISO   = 5;
	localparam int SL_MOSI   = 6;
	localparam int SL_SS     = 7;
	localparam int SL_SYSCLK = 8;
	localparam int SL_CP0    = 9;
	localparam int SL_CP0A   = 10;
	localparam int SL_CP1    = 11;
	localparam int SL_CP1A   = 12;
	localparam int SL_CEX0   = 13;
	localparam int SL_ECI    = 19;
	localparam int SL_T0     = 20;
	localparam int SL_T1     = 21;
	localparam int NCEX      = 6;
	localparam int PIN_TX    = 4;
	localparam int PIN_RX    = 5;

	// ==================================================================
	// Bus response codes.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ==================================================================
	// Carrier types.
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} pcx_axi_req_s;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} pcx_axi_rsp_s;

	typedef struct packed {
		logic [NPIN-1:0] out;
		logic [NPIN-1:0] oe;
		logic [NPIN-1:0] pullupEn;
		logic [NPIN-1:0] rxEn;
	} pcx_pin_s;

endpackage : pcx_pkg

// File: rtl/pcx_crossbar.sv
// Priority crossbar and per-pin port configuration with AXI4-Lite access.
//
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/100ps
`default_nettype none

module pcx_crossbar (
	// Clock and reset.
	input  wire logic                          clk,
	input  wire logic                          rst_n,
	// Register bus.
	input  wire pcx_pkg::pcx_axi_req_s         axiReq,
	output var  pcx_pkg::pcx_axi_rsp_s         axiRsp,
	// Physical pins.
	input  wire logic [pcx_pkg::NPIN-1:0]      pinIn,
	output var  pcx_pkg::pcx_pin_s             pins,
	output var  logic [7:0]                    overdriveHiZ,
	// Peripheral function side.
	input  wire logic [pcx_pkg::NFUNC-1:0]     funcOut,
	input  wire logic [pcx_pkg::NFUNC-1:0]     funcOe,
	output var  logic [pcx_pkg::NFUNC-1:0]     funcIn
);

	// ==================================================================
	// State.
	typedef struct packed {
		logic [7:0]                       fsa;
		logic [7:0]                       fsb;
		logic [1:0]                       ssMode;
		logic [23:0]                      inMode;
		logic [23:0]                      outMode;
		logic [23:0]                      skip;
		logic [23:0]                      latch;
		logic [7:0]                       odMode;
		logic [pcx_pkg::NPIN-1:0][4:0]    pinMap;
		pcx_pkg::pcx_pin_s                pins;
		logic [pcx_pkg::NFUNC-1:0]        funcIn;
		logic                             awHeld;
		logic [pcx_pkg::ADDR_W-1:0]       awAddr;
		logic                             wHeld;
		logic [31:0]                      wData;
		logic [3:0]                       wStrb;
		pcx_pkg::pcx_axi_rsp_s            rsp;
	} pcx_state_s;

	pcx_state_s s;
	pcx_state_s next_s;

	// ==================================================================
	// Helpers.
	function automatic logic [31:0] mergeStrb(input logic [31:0] old,
			input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = data[8*b +: 8];
			end
		end
		return r;
	endfunction : mergeStrb

	function automatic logic addrKnown(input logic [pcx_pkg::ADDR_W-1:0] a);
		logic [7:0] o;
		o = a;
		return o == pcx_pkg::OFF_FUNC_SEL_A || o == pcx_pkg::OFF_FUNC_SEL_B ||
			o == pcx_pkg::OFF_SPI_CTRL || o == pcx_pkg::OFF_IN_MODE ||
			o == pcx_pkg::OFF_OUT_MODE || o == pcx_pkg::OFF_SKIP ||
			o == pcx_pkg::OFF_PORT || o == pcx_pkg::OFF_OVERDRIVE ||
			o == pcx_pkg::OFF_LATCH;
	endfunction : addrKnown

	// ==================================================================
	// Function enables in priority order.
	logic [pcx_pkg::NFUNC-1:0] funcEn;

	always_comb begin
		logic [2:0] pca;
		pca = s.fsb[pcx_pkg::FB_PCA_LO +: 3];
		funcEn = '0;
		funcEn[pcx_pkg::SL_TX]   = s.fsa[pcx_pkg::FA_UART];
		funcEn[pcx_pkg::SL_RX]   = s.fsa[pcx_pkg::FA_UART];
		funcEn[pcx_pkg::SL_SDA]  = s.fsa[pcx_pkg::FA_SMB];
		funcEn[pcx_pkg::SL_SCL]  = s.fsa[pcx_pkg::FA_SMB];
		funcEn[pcx_pkg::SL_SCK]  = s.fsa[pcx_pkg::FA_SPI];
		funcEn[pcx_pkg::SL_MISO] = s.fsa[pcx_pkg::FA_SPI];
		funcEn[pcx_pkg::SL_MOSI] = s.fsa[pcx_pkg::FA_SPI];
		funcEn[pcx_pkg::SL_SS]   = s.fsa[pcx_pkg::FA_SPI] &&
			s.ssMode != pcx_pkg::SSMODE_3WIRE;
		funcEn[pcx_pkg::SL_SYSCLK] = s.fsa[pcx_pkg::FA_SYSCLK];
		funcEn[pcx_pkg::SL_CP0]  = s.fsa[pcx_pkg::FA_CP0];
		funcEn[pcx_pkg::SL_CP0A] = s.fsa[pcx_pkg::FA_CP0A];
		funcEn[pcx_pkg::SL_CP1]  = s.fsa[pcx_pkg::FA_CP1];
		funcEn[pcx_pkg::SL_CP1A] = s.fsa[pcx_pkg::FA_CP1A];
		for (int c = 0; c < pcx_pkg::NCEX; c++) begin
			funcEn[pcx_pkg::SL_CEX0 + c] = pca != pcx_pkg::PCA_RESERVED &&
				c < int'(pca);
		end
		funcEn[pcx_pkg::SL_ECI] = s.fsb[pcx_pkg::FB_ECI];
		funcEn[pcx_pkg::SL_T0]  = s.fsb[pcx_pkg::FB_T0];
		funcEn[pcx_pkg::SL_T1]  = s.fsb[pcx_pkg::FB_T1];
	end

	// ==================================================================
	// Priority placement of functions onto pins.
	logic [pcx_pkg::NPIN-1:0][4:0] mapCalc;

	always_comb begin
		logic [pcx_pkg::NPIN-1:0] taken;
		logic                     found;
		taken = s.skip;
		found = 1'b0;
		mapCalc = '0;
		if (funcEn[pcx_pkg::SL_TX]) begin
			// The serial pins are fixed and ignore skip bits.
			mapCalc[pcx_pkg::PIN_TX] = 5'(pcx_pkg::SL_TX + 1);
			mapCalc[pcx_pkg::PIN_RX] = 5'(pcx_pkg::SL_RX + 1);
			taken[pcx_pkg::PIN_TX] = 1'b1;
			taken[pcx_pkg::PIN_RX] = 1'b1;
		end
		for (int f = pcx_pkg::SL_SDA; f < pcx_pkg::NFUNC; f++) begin
			found = 1'b0;
			for (int p = 0; p < pcx_pkg::NPIN; p++) begin
				if (funcEn[f] && !found && !taken[p]) begin
					mapCalc[p] = 5'(f + 1);
					taken[p] = 1'b1;
					found = 1'b1;
				end
			end
		end
	end

	// ==================================================================
	// Pin drive, pullups and function inputs.
	pcx_pkg::pcx_pin_s         pinCalc;
	logic [pcx_pkg::NFUNC-1:0] funcInCalc;

	always_comb begin
		logic d;
		logic want;
		logic od;
		logic xbarOn;
		d = 1'b0;
		want = 1'b0;
		od = 1'b0;
		xbarOn = s.fsb[pcx_pkg::FB_CROSSBAR_ENABLE_BIT];
		pinCalc = '0;
		funcInCalc = '0;
		for (int p = 0; p < pcx_pkg::NPIN; p++) begin
			d = s.latch[p];
			want = 1'b1;
			od = !s.outMode[p];
			for (int f = 0; f < pcx_pkg::NFUNC; f++) begin
				if (s.pinMap[p] == 5'(f + 1)) begin
					d = funcOut[f];
					want = funcOe[f];
					funcInCalc[f] = pinIn[p] & s.inMode[p];
					if (f == pcx_pkg::SL_SDA || f == pcx_pkg::SL_SCL) begin
						od = 1'b1;
					end
				end
			end
			pinCalc.rxEn[p] = s.inMode[p];
			pinCalc.out[p] = d && !od;
			// Drivers stay off until the crossbar is on and pin is digital.
			pinCalc.oe[p] = xbarOn && s.inMode[p] && want &&
				(!od || !d);
			pinCalc.pullupEn[p] = !s.fsb[pcx_pkg::FB_PULLUP_DISABLE_BIT] && od &&
				s.inMode[p] && !pinCalc.oe[p];
		end
	end

	// ==================================================================
	// Register read view.
	function automatic logic [31:0] readReg(input pcx_state_s st,
			input logic [pcx_pkg::ADDR_W-1:0] a,
			input logic [pcx_pkg::NPIN-1:0] pin);
		logic [31:0] r;
		r = '0;
		unique case (8'(a))
			pcx_pkg::OFF_FUNC_SEL_A: r[7:0] = st.fsa;
			pcx_pkg::OFF_FUNC_SEL_B: r[7:0] = st.fsb;
			pcx_pkg::OFF_SPI_CTRL:   r[1:0] = st.ssMode;
			pcx_pkg::OFF_IN_MODE:    r[23:0] = st.inMode;
			pcx_pkg::OFF_OUT_MODE:   r[23:0] = st.outMode;
			pcx_pkg::OFF_SKIP:       r[23:0] = st.skip;
			pcx_pkg::OFF_PORT:       r[23:0] = pin & st.inMode;
			pcx_pkg::OFF_OVERDRIVE:  r[7:0] = st.odMode;
			pcx_pkg::OFF_LATCH:      r[23:0] = st.latch;
			default:                 r = '0;
		endcase
		return r;
	endfunction : readReg

	// ==================================================================
	// Next state: bus slave, register writes, registered outputs.
	always_comb begin
		logic [31:0] wv;
		wv = '0;
		next_s = s;
		next_s.pinMap = mapCalc;
		next_s.pins = pinCalc;
		next_s.funcIn = funcInCalc;

		if (axiReq.awvalid && s.rsp.awready) begin
			next_s.awHeld = 1'b1;
			next_s.awAddr = axiReq.awaddr;
			next_s.rsp.awready = 1'b0;
		end
		if (axiReq.wvalid && s.rsp.wready) begin
			next_s.wHeld = 1'b1;
			next_s.wData = axiReq.wdata;
			next_s.wStrb = axiReq.wstrb;
			next_s.rsp.wready = 1'b0;
		end
		if (s.awHeld && s.wHeld && !s.rsp.bvalid) begin
			next_s.awHeld = 1'b0;
			next_s.wHeld = 1'b0;
			next_s.rsp.bvalid = 1'b1;
			next_s.rsp.bresp = addrKnown(s.awAddr) ? pcx_pkg::RESP_OKAY :
				pcx_pkg::RESP_SLVERR;
			unique case (8'(s.awAddr))
				pcx_pkg::OFF_FUNC_SEL_A: begin
					wv = mergeStrb({24'h0, s.fsa}, s.wData, s.wStrb);
					next_s.fsa = wv[7:0];
				end
				pcx_pkg::OFF_FUNC_SEL_B: begin
					wv = mergeStrb({24'h0, s.fsb}, s.wData, s.wStrb);
					next_s.fsb = wv[7:0];
				end
				pcx_pkg::OFF_SPI_CTRL: begin
					wv = mergeStrb({30'h0, s.ssMode}, s.wData, s.wStrb);
					next_s.ssMode = wv[1:0];
				end
				pcx_pkg::OFF_IN_MODE: begin
					wv = mergeStrb({8'h0, s.inMode}, s.wData, s.wStrb);
					next_s.inMode = wv[23:0];
				end
				pcx_pkg::OFF_OUT_MODE: begin
					wv = mergeStrb({8'h0, s.outMode}, s.wData, s.wStrb);
					next_s.outMode = wv[23:0];
				end
				pcx_pkg::OFF_SKIP: begin
					wv = mergeStrb({8'h0, s.skip}, s.wData, s.wStrb);
					next_s.skip = wv[23:0];
				end
				pcx_pkg::OFF_PORT, pcx_pkg::OFF_LATCH: begin
					wv = mergeStrb({8'h0, s.latch}, s.wData, s.wStrb);
					next_s.latch = wv[23:0];
				end
				pcx_pkg::OFF_OVERDRIVE: begin
					wv = mergeStrb({24'h0, s.odMode}, s.wData, s.wStrb);
					next_s.odMode = wv[7:0];
				end
				default: wv = '0;
			endcase
		end
		if (s.rsp.bvalid && axiReq.bready) begin
			next_s.rsp.bvalid = 1'b0;
			next_s.rsp.awready = 1'b1;
			next_s.rsp.wready = 1'b1;
		end

		if (axiReq.arvalid && s.rsp.arready) begin
			next_s.rsp.arready = 1'b0;
			next_s.rsp.rvalid = 1'b1;
			next_s.rsp.rdata = readReg(s, axiReq.araddr, pinIn);
			next_s.rsp.rresp = addrKnown(axiReq.araddr) ?
				pcx_pkg::RESP_OKAY : pcx_pkg::RESP_SLVERR;
		end
		if (s.rsp.rvalid && axiReq.rready) begin
			next_s.rsp.rvalid = 1'b0;
			next_s.rsp.arready = 1'b1;
		end
	end

	// ==================================================================
	// State register.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.fsa <= pcx_pkg::FSEL_RST;
			s.fsb <= pcx_pkg::FSEL_RST;
			s.ssMode <= pcx_pkg::SSMODE_RST;
			s.inMode <= pcx_pkg::IN_MODE_RST;
			s.pins.rxEn <= '1;
			s.outMode <= pcx_pkg::OUT_MODE_RST;
			s.skip <= pcx_pkg::SKIP_RST;
			s.latch <= pcx_pkg::LATCH_RST;
			s.odMode <= pcx_pkg::OD_RST;
			s.rsp.awready <= 1'b1;
			s.rsp.wready <= 1'b1;
			s.rsp.arready <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	// ==================================================================
	// Outputs.
	assign axiRsp = s.rsp;
	assign pins = s.pins;
	assign overdriveHiZ = s.odMode;
	assign funcIn = s.funcIn;

endmodule : pcx_crossbar

`default_nettype wire

// File: bench/pcx_assertions.sv
// Checker of bus answers and pin drive relations of the crossbar.
`timescale 1ns/100ps
`default_nettype none

module pcx_assertions (
	// Clock and reset.
	input wire logic			clk,
	input wire logic			rst_n,
	// Register bus and pins.
	input wire pcx_pkg::pcx_axi_req_s	axiReq,
	input wire pcx_pkg::pcx_axi_rsp_s	axiRsp,
	input wire pcx_pkg::pcx_pin_s	pins,
	input wire logic [7:0]		overdriveHiZ
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	logic		wrNow;
	logic		xbOn;
	logic [2:0]	offAge;

	assign wrNow = axiReq.awvalid && axiRsp.awready && axiReq.wvalid
		&& axiRsp.wready;

	sequence wrTake;
		wrNow;
	endsequence
	sequence odWrite;
		wrTake ##0 (axiReq.awaddr == pcx_pkg::OFF_OVERDRIVE);
	endsequence

	// Tracks the crossbar enable bit and how many cycles ago function_select_b was last written.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			xbOn <= 1'b0;
			offAge <= 3'h7;
		end else if (wrNow && axiReq.wstrb[0] &&
				axiReq.awaddr == pcx_pkg::OFF_FUNC_SEL_B) begin
			xbOn <= axiReq.wdata[pcx_pkg::FB_CROSSBAR_ENABLE_BIT];
			offAge <= 3'h0;
		end else if (offAge != 3'h7) begin
			offAge <= offAge + 3'h1;
		end
	end

	AST_XBAR_OFF: assert property (
		!xbOn && offAge > 3'h3 |-> pins.oe == '0)
		else $error("driver on, crossbar off");
	AST_ANALOG_OFF: assert property (
		(~pins.rxEn & (pins.oe | pins.pullupEn)) == '0)
		else $error("analog pin not idle");
	AST_PULL_DRIVEN: assert property (
		(pins.oe & pins.pullupEn) == '0)
		else $error("pullup on a driven pin");
	AST_RESET_STATE: assert property (
		$rose(rst_n) |-> pins.oe == '0 && pins.rxEn == '1)
		else $error("pins not inputs after reset");
	AST_OD_WRITE: assert property (
		odWrite |-> ##2 overdriveHiZ == $past(axiReq.wdata[7:0], 2))
		else $error("overdrive not written");
	AST_B_AFTER_W: assert property (
		wrTake |-> ##2 axiRsp.bvalid)
		else $error("late write answer");
	AST_R_AFTER_AR: assert property (
		axiReq.arvalid && axiRsp.arready |=> axiRsp.rvalid && !axiRsp.arready)
		else $error("late read answer");
	AST_UNMAPPED_RD: assert property (
		axiReq.arvalid && axiRsp.arready && axiReq.araddr > pcx_pkg::OFF_LATCH
		|=> axiRsp.rresp == pcx_pkg::RESP_SLVERR && axiRsp.rdata == 32'h0)
		else $error("unmapped read answered");
endmodule : pcx_assertions

bind pcx_crossbar pcx_assertions u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.axiReq(axiReq),
	.axiRsp(axiRsp),
	.pins(pins),
	.overdriveHiZ(overdriveHiZ)
);

`default_nettype wire

// File: bench/pcx_board.sv
// Board model that resolves each pin from device and outside drivers.
`timescale 1ns/100ps
`default_nettype none

module pcx_board (
	// Clock.
	input wire logic		clk,
	// Device side.
	input wire pcx_pkg::pcx_pin_s	pins,
	// Outside drivers set by the bench.
	input wire logic [23:0]	extDrv,
	input wire logic [23:0]	extVal,
	// Resolved levels.
	output var logic [23:0]	pinIn
);
	logic [23:0] lastLvl = '0;

	// A floating pin shows the inverse of its last level.
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (pins.oe[i])
				pinIn[i] = pins.out[i];
			else if (extDrv[i])
				pinIn[i] = extVal[i];
			else if (pins.pullupEn[i])
				pinIn[i] = 1'b1;
			else
				pinIn[i] = ~lastLvl[i];
		end
	end

	always_ff @(posedge clk) begin
		lastLvl <= pinIn;
	end
endmodule : pcx_board

`default_nettype wire

// File: bench/testbench.sv
// Self-checking bench of the port crossbar over its register bus.
`timescale 1ns/100ps
`default_nettype none

module testbench;
	logic				clk = 1'b0;
	logic				rst_n;
	pcx_pkg::pcx_axi_req_s	req;
	pcx_pkg::pcx_axi_rsp_s	rsp;
	pcx_pkg::pcx_pin_s		pins;
	logic [23:0]			pinIn;
	logic [23:0]			extDrv;
	logic [23:0]			extVal;
	logic [21:0]			fOut;
	logic [21:0]			fOe;
	logic [7:0]			odHiZ;
	logic [31:0]			ex;
	logic [1:0]			bResp;
	logic [21:0]			fIn;
	int				n_fail = 0;
	int				compares = 0;
	// Cases: functions, slave select mode, skips, expected low out byte.
	logic [7:0] tSel[6] = '{8'h01, 8'h04, 8'h04, 8'h02, 8'h03, 8'h05};
	logic [1:0] tSs[6] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h1, 2'h0};
	logic [7:0] tSkip[6] = '{8'h30, 8'h00, 8'h03, 8'h00, 8'h05, 8'h0f};
	logic [7:0] tOut[6] = '{8'hcf, 8'hfc, 8'hf3, 8'hf8, 8'h05, 8'h0f};

	always #2 clk = ~clk;

	pcx_crossbar DUT (
		.clk(clk),
		.rst_n(rst_n),
		.axiReq(req),
		.axiRsp(rsp),
		.pinIn(pinIn),
		.pins(pins),
		.overdriveHiZ(odHiZ),
		.funcOut(fOut),
		.funcOe(fOe),
		.funcIn(fIn)
	);
	pcx_board u_board (
		.clk(clk),
		.pins(pins),
		.extDrv(extDrv),
		.extVal(extVal),
		.pinIn(pinIn)
	);

	// ================================================================
	// Tasks.
	task automatic report_and_stop();
		$display("compares %0d, mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : report_and_stop

	task automatic timeout();
		n_fail++;
		$display("wait ran out");
		report_and_stop();
	endtask : timeout

	task automatic chk(input string nm, input logic [31:0] seen, exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		int k;
		req.awaddr <= a;
		req.wdata <= d;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (rsp.awready)
				req.awvalid <= 1'b0;
			if (rsp.wready)
				req.wvalid <= 1'b0;
			if (rsp.bvalid)
				break;
		end
		bResp = rsp.bresp;
		if (k == 40)
			timeout();
	endtask : wr

	task automatic rchk(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		int k;
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		for (k = 0; k < 40; k++) begin
			@(posedge clk);
			if (rsp.arready)
				req.arvalid <= 1'b0;
			if (rsp.rvalid)
				break;
		end
		chk("rdata", rsp.rdata, d);
		chk("rresp", 32'(rsp.rresp), 32'(r));
		if (k == 40)
			timeout();
	endtask : rchk

	task automatic settle();
		repeat (3) @(posedge clk);
	endtask : settle

	// ================================================================
	// Main sequence.
	initial begin
		rst_n = 1'b0;
		req = '0;
		req.wstrb = 4'hf;
		extDrv = '0;
		extVal = '0;
		fOut = '0;
		fOe = '1;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk("oe", 32'(pins.oe), 32'h0);
		chk("rxEn", 32'(pins.rxEn), 32'hffffff);
		rchk(pcx_pkg::OFF_IN_MODE, 32'hffffff, 2'h0);
		rchk(8'h3c, 32'h0, pcx_pkg::RESP_SLVERR);
		wr(8'h3c, 32'h1);
		chk("bresp", 32'(bResp), 32'(pcx_pkg::RESP_SLVERR));
		rchk(pcx_pkg::OFF_FUNC_SEL_A, 32'h0, 2'h0);
		extDrv <= '1;
		extVal <= 24'h5a3c96;
		settle();
		rchk(pcx_pkg::OFF_PORT, 32'h5a3c96, 2'h0);
		$display("test reset done");
		extDrv <= '0;
		wr(pcx_pkg::OFF_OUT_MODE, 32'hffffff);
		wr(pcx_pkg::OFF_PORT, 32'h0);
		settle();
		chk("oe off", 32'(pins.oe), 32'h0);
		wr(pcx_pkg::OFF_FUNC_SEL_B, 32'h40);
		settle();
		chk("oe on", 32'(pins.oe), 32'hffffff);
		chk("pull pp", 32'(pins.pullupEn), 32'h0);
		$display("test gpio done");
		wr(pcx_pkg::OFF_PORT, 32'hffffff);
		for (int i = 0; i < 6; i++) begin
			wr(pcx_pkg::OFF_SKIP, {24'h0, tSkip[i]});
			wr(pcx_pkg::OFF_SPI_CTRL, {30'h0, tSs[i]});
			wr(pcx_pkg::OFF_FUNC_SEL_A, {24'h0, tSel[i]});
			settle();
			ex = {16'hffff, tOut[i]};
			chk("route", 32'(pins.out), ex);
		end
		fOut[pcx_pkg::SL_SDA] <= 1'b1;
		settle();
		chk("sda oe", 32'(pins.oe[6]), 32'h0);
		chk("sda pull", 32'(pins.pullupEn[6]), 32'h1);
		chk("func in", 32'(fIn), 32'h4);
		wr(pcx_pkg::OFF_FUNC_SEL_B, 32'h42);
		settle();
		chk("pca", 32'(pins.out), 32'hfffc0f);
		wr(pcx_pkg::OFF_FUNC_SEL_B, 32'h47);
		settle();
		chk("pca none", 32'(pins.out), 32'hffff0f);
		$display("test routing done");
		wr(pcx_pkg::OFF_OUT_MODE, 32'h0);
		fOut <= '1;
		settle();
		chk("od oe", 32'(pins.oe), 32'h0);
		chk("od pull", 32'(pins.pullupEn), 32'hffffff);
		wr(pcx_pkg::OFF_FUNC_SEL_B, 32'hc0);
		settle();
		chk("pud", 32'(pins.pullupEn), 32'h0);
		wr(pcx_pkg::OFF_FUNC_SEL_B, 32'h40);
		wr(pcx_pkg::OFF_PORT, 32'h1);
		wr(pcx_pkg::OFF_IN_MODE, 32'hfffffe);
		extDrv <= 24'h1;
		extVal <= 24'h1;
		settle();
		chk("low oe", 32'(pins.oe), 32'hffff0e);
		chk("low pull", 32'(pins.pullupEn), 32'hf0);
		chk("rxEn", 32'(pins.rxEn), 32'hfffffe);
		rchk(pcx_pkg::OFF_PORT, 32'hf0, 2'h0);
		$display("test modes done");
		wr(pcx_pkg::OFF_OVERDRIVE, 32'ha5);
		settle();
		chk("odz", 32'(odHiZ), 32'ha5);
		chk("bresp ok", 32'(bResp), 32'(pcx_pkg::RESP_OKAY));
		rchk(pcx_pkg::OFF_OVERDRIVE, 32'ha5, 2'h0);
		$display("test overdrive done");
		report_and_stop();
	end
endmodule : testbench

`default_nettype wire
